// ### src/data_flash_page_sequencer.sv
// Page sequencer for a 640-byte nonvolatile data array
// Assumes a core register port with one-cycle write strobes
//
// How it works
// - Five operation codes: read, program, verify, page erase, full erase.
// - Writing a valid code starts its operation in the same cycle.
// - Core stall output stays high while an operation runs.
// - Interrupt hold output mirrors the stall; other logic runs on.
// - Full erase stalls the core for the full-erase count plus two cycles.
// - Page erase stalls the core for the page-erase count plus two cycles.
// - Program stalls the core for the program count plus two cycles.
// - Read loads the data registers the cycle after the command.
// - Page erase sets all four bytes of one page to all ones.
// - Full erase sets all 640 bytes to all ones.
// - Array comes out of reset erased, all ones.
// - Code 01H copies page to data registers; 02H writes them back.
// - Code 04H compares; command reads zero on match, nonzero otherwise.
// - Code 05H erases the page; 03H and 07H-FFH do nothing.
// - Address picks pages 00H-9FH; registers reset to zero.
`timescale 1ns/100ps
`include "flash_seq_consts.svh"
module data_flash_page_sequencer
  import flash_seq_pkg::*;
#(
  parameter int unsigned ERASE_ALL_CYCLES = `ERASE_ALL_CYCLES,
  parameter int unsigned ERASE_PAGE_CYCLES = `ERASE_PAGE_CYCLES,
  parameter int unsigned PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Core register port
  input wire logic cmd_wr_i,
  input wire logic addr_wr_i,
  input wire logic [3:0] data_wr_i,
  input wire logic [7:0] wdata_i,
  // Register contents
  output logic [7:0] array_command_o,
  output logic [7:0] page_address_o,
  output logic [31:0] page_data_o,
  // Core control
  output logic core_stall_o,
  output logic irq_hold_o
);
  localparam int unsigned CW = 20;
  localparam int unsigned BYTES = `PAGE_COUNT * 4;

  byte_t array_command_reg;
  byte_t page_address_reg;
  byte_t page_data_regs [4];
  byte_t mem [BYTES];
  seq_state_e state_reg;
  logic [CW-1:0] count_reg;

  function automatic logic is_valid_op(input byte_t op, input byte_t adr);
    logic ok;
    ok = (op == `OP_ERASE_ALL) ||
         (((op == `OP_READ) || (op == `OP_PROGRAM) || (op == `OP_VERIFY) ||
           (op == `OP_ERASE_PAGE)) && (adr <= `LAST_PAGE));
    return ok;
  endfunction : is_valid_op

  function automatic logic [CW-1:0] op_cycles(input byte_t op);
    logic [CW-1:0] c;
    c = CW'(1);
    case (op)
      `OP_PROGRAM: c = CW'(PROGRAM_CYCLES);
      `OP_ERASE_PAGE: c = CW'(ERASE_PAGE_CYCLES);
      `OP_ERASE_ALL: c = CW'(ERASE_ALL_CYCLES);
      default: c = CW'(1);
    endcase
    return c;
  endfunction : op_cycles

  logic start;
  logic [9:0] base;
  assign start = cmd_wr_i && (state_reg == ST_IDLE) &&
                 is_valid_op(wdata_i, page_address_reg);
  assign base = {page_address_reg[7:0], 2'b00};

  // Operation sequencing
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_WAIT;
            count_reg <= op_cycles(wdata_i);
          end
        end
        ST_WAIT: begin
          if (count_reg <= CW'(1)) begin
            state_reg <= ST_DONE;
          end
          count_reg <= count_reg - CW'(1);
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign core_stall_o = (state_reg != ST_IDLE) || start;
  assign irq_hold_o = core_stall_o;

  // Address register
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      page_address_reg <= `REG_RESET;
    end else if (addr_wr_i && !core_stall_o) begin
      page_address_reg <= wdata_i;
    end
  end

  // Command register, verify result
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      array_command_reg <= `REG_RESET;
    end else if (cmd_wr_i && state_reg == ST_IDLE) begin
      array_command_reg <= wdata_i;
      if (start && wdata_i == `OP_VERIFY) begin
        array_command_reg <= `REG_RESET;
        for (int i = 0; i < 4; i++) begin
          if (mem[base + 10'(i)] != page_data_regs[i]) begin
            array_command_reg <= `VERIFY_FAIL;
          end
        end
      end
    end
  end

  // Data registers
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 4; i++) begin
        page_data_regs[i] <= `REG_RESET;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (start && wdata_i == `OP_READ) begin
          page_data_regs[i] <= mem[base + 10'(i)];
        end else if (data_wr_i[i] && !core_stall_o) begin
          page_data_regs[i] <= wdata_i;
        end
      end
    end
  end

  // Array contents
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int j = 0; j < BYTES; j++) begin
        mem[j] <= `ERASED_BYTE;
      end
    end else if (start) begin
      case (wdata_i)
        `OP_PROGRAM: begin
          for (int i = 0; i < 4; i++) begin
            mem[base + 10'(i)] <= page_data_regs[i];
          end
        end
        `OP_ERASE_PAGE: begin
          for (int i = 0; i < 4; i++) begin
            mem[base + 10'(i)] <= `ERASED_BYTE;
          end
        end
        `OP_ERASE_ALL: begin
          for (int j = 0; j < BYTES; j++) begin
            mem[j] <= `ERASED_BYTE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign array_command_o = array_command_reg;
  assign page_address_o = page_address_reg;
  assign page_data_o = {page_data_regs[3], page_data_regs[2],
                        page_data_regs[1], page_data_regs[0]};

  // Assertion helper: length of the current stall and its command
  logic [CW-1:0] stall_len_reg;
  byte_t watch_op_reg;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stall_len_reg <= '0;
      watch_op_reg <= `REG_RESET;
    end else if (start) begin
      stall_len_reg <= CW'(1);
      watch_op_reg <= wdata_i;
    end else if (state_reg != ST_IDLE) begin
      stall_len_reg <= stall_len_reg + CW'(1);
    end
  end

  // Stall timing
  stall_release_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == ST_DONE) |=> (core_stall_o == start))
    else $error("Stall not released after done");
  done_idle_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == ST_DONE) |=> (state_reg == ST_IDLE))
    else $error("Sequencer did not return to idle");
  stall_length_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (state_reg == ST_DONE) |->
    (stall_len_reg == ((watch_op_reg == `OP_PROGRAM) ?
      CW'(PROGRAM_CYCLES + 1) :
      (watch_op_reg == `OP_ERASE_PAGE) ? CW'(ERASE_PAGE_CYCLES + 1) :
      (watch_op_reg == `OP_ERASE_ALL) ? CW'(ERASE_ALL_CYCLES + 1) :
      CW'(2))))
    else $error("Stall length differs from its count");
  prog_stall_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (start && wdata_i == `OP_PROGRAM && PROGRAM_CYCLES >= 3) |=>
    core_stall_o [*4])
    else $error("Program did not stall");
  stall_start_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    start |=> core_stall_o [*2])
    else $error("Start without stall");
  irq_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    irq_hold_o == core_stall_o)
    else $error("Interrupt hold differs from stall");
  reserved_op_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (cmd_wr_i && state_reg == ST_IDLE &&
     !is_valid_op(wdata_i, page_address_reg)) |->
    !core_stall_o ##1 (state_reg == ST_IDLE))
    else $error("Reserved op stalled core");
  start_op_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    start |=> state_reg == ST_WAIT)
    else $error("Command did not start");

  // Register writes
  addr_write_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (addr_wr_i && !core_stall_o) |=> page_address_reg == $past(wdata_i))
    else $error("Address write lost");
  addr_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (addr_wr_i && core_stall_o) |=> $stable(page_address_reg))
    else $error("Address changed during stall");
  data_hold_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (data_wr_i != 4'h0 && core_stall_o && !start) |=> $stable(page_data_o))
    else $error("Data changed during stall");
  cmd_store_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (cmd_wr_i && state_reg == ST_IDLE &&
     !(start && wdata_i == `OP_VERIFY)) |=>
    array_command_reg == $past(wdata_i))
    else $error("Command write lost");
  verify_result_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (start && wdata_i == `OP_VERIFY) |=>
    ((array_command_reg == `REG_RESET) ==
     ($past(page_data_o) == {mem[$past(base) + 10'd3],
      mem[$past(base) + 10'd2], mem[$past(base) + 10'd1],
      mem[$past(base)]})))
    else $error("Verify result wrong");

  // Array and data contents
  read_load_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (start && wdata_i == `OP_READ) |=>
    page_data_regs[0] == $past(mem[base]))
    else $error("Read did not load data");
  erase_page_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (start && wdata_i == `OP_ERASE_PAGE) |=>
    mem[$past(base) + 10'd3] == `ERASED_BYTE)
    else $error("Page erase missed byte");
  erase_all_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (start && wdata_i == `OP_ERASE_ALL) |=>
    mem[BYTES-1] == `ERASED_BYTE && mem[0] == `ERASED_BYTE)
    else $error("Full erase incomplete");

  // Per-byte checks on the data registers and the addressed page
  for (genvar b = 0; b < 4; b++) begin : g_byte_chk
    data_write_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (data_wr_i[b] && !core_stall_o) |=>
      page_data_regs[b] == $past(wdata_i))
      else $error("Data register write lost");
    erase_byte_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (start && wdata_i == `OP_ERASE_PAGE) |=>
      mem[$past(base) + 10'(b)] == `ERASED_BYTE)
      else $error("Page erase left a byte");
    program_byte_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (start && wdata_i == `OP_PROGRAM) |=>
      mem[$past(base) + 10'(b)] == $past(page_data_regs[b]))
      else $error("Program missed a byte");
    read_byte_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      (start && wdata_i == `OP_READ) |=>
      page_data_regs[b] == mem[$past(base) + 10'(b)])
      else $error("Read missed a byte");
  end
endmodule : data_flash_page_sequencer

// ### src/flash_seq_consts.svh
// Constants for the data array page sequencer
// Assumes inclusion by the package and the sequencer module
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH
`define CLK_PERIOD_PS 5000
`define ERASE_ALL_TIME_US 2000
`define ERASE_PAGE_TIME_US 2000
`define PROGRAM_TIME_US 250
`define ERASE_ALL_CYCLES ((`ERASE_ALL_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define ERASE_PAGE_CYCLES ((`ERASE_PAGE_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define PROGRAM_CYCLES ((`PROGRAM_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define OP_READ 8'h01
`define OP_PROGRAM 8'h02
`define OP_VERIFY 8'h04
`define OP_ERASE_PAGE 8'h05
`define OP_ERASE_ALL 8'h06
`define PAGE_COUNT 160
`define LAST_PAGE 8'h9F
`define ERASED_BYTE 8'hFF
`define REG_RESET 8'h00
`define VERIFY_FAIL 8'h01
`endif

// ### src/flash_seq_pkg.sv
// Types for the data array page sequencer
// Assumes the constants header is on the include path
`include "flash_seq_consts.svh"
package flash_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } seq_state_e;
  typedef logic [7:0] byte_t;
endpackage : flash_seq_pkg

// ### verification/core_port_model.sv
// Core register port model for the page sequencer
// Assumes strobes are sampled on the rising clock edge
`timescale 1ns/100ps
module core_port_model (
  // Clock
  input wire logic sys_clk_i,
  // Sequencer status
  input wire logic stall_i,
  input wire logic hold_i,
  // Register writes
  output logic cmd_wr_o,
  output logic addr_wr_o,
  output logic [3:0] data_wr_o,
  output logic [7:0] wdata_o
);
  initial begin
    cmd_wr_o <= 1'b0;
    addr_wr_o <= 1'b0;
    data_wr_o <= 4'h0;
    wdata_o <= 8'h00;
  end
  // Loads address (sel 4) or a data byte before a command
  task automatic put(input int sel, input logic [7:0] v);
    @(posedge sys_clk_i);
    if (sel == 4) addr_wr_o <= 1'b1;
    else data_wr_o <= 4'h1 << sel;
    wdata_o <= v;
    @(posedge sys_clk_i);
    addr_wr_o <= 1'b0;
    data_wr_o <= 4'h0;
    wdata_o <= ~v;
  endtask : put
  // Writes a command, then counts stalled cycles
  task automatic run(input logic [7:0] code, output int n, output int sk);
    n = 0;
    sk = 0;
    @(posedge sys_clk_i);
    cmd_wr_o <= 1'b1;
    wdata_o <= code;
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk_i);
      if (hold_i !== stall_i) sk++;
      if (stall_i !== 1'b1) break;
      n++;
      if (i == 0) @(posedge sys_clk_i) cmd_wr_o <= 1'b0;
    end
    @(posedge sys_clk_i);
    cmd_wr_o <= 1'b0;
    wdata_o <= ~code;
  endtask : run
endmodule : core_port_model

// ### verification/tb.sv
// Self-checking bench for the data array page sequencer
// Assumes short duration counts passed as parameters
`timescale 1ns/100ps
module tb;
  import flash_seq_pkg::*;
  localparam int EA = 6;
  localparam int EP = 5;
  localparam int PG = 4;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_wr, addr_wr, stall, hold;
  logic [3:0] data_wr;
  logic [7:0] wdata, cmd_q, addr_q;
  logic [31:0] data_q;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n, sk;
  always #2.5 sys_clk_i = ~sys_clk_i;
  data_flash_page_sequencer #(.ERASE_ALL_CYCLES(EA),
    .ERASE_PAGE_CYCLES(EP), .PROGRAM_CYCLES(PG))
    data_flash_page_sequencer_inst (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .cmd_wr_i(cmd_wr), .addr_wr_i(addr_wr),
    .data_wr_i(data_wr), .wdata_i(wdata), .array_command_o(cmd_q),
    .page_address_o(addr_q), .page_data_o(data_q),
    .core_stall_o(stall), .irq_hold_o(hold));
  core_port_model core_port_model_inst (.sys_clk_i(sys_clk_i),
    .stall_i(stall), .hold_i(hold), .cmd_wr_o(cmd_wr),
    .addr_wr_o(addr_wr), .data_wr_o(data_wr), .wdata_o(wdata));
  task automatic chk(input string what, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic op(input logic [7:0] code, input int e);
    core_port_model_inst.run(code, n, sk);
    @(negedge sys_clk_i);
    chk("stall cycles", e, n);
    chk("hold skew", 0, sk);
  endtask : op
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic t_reset;
    chk("command", 8'h00, cmd_q);
    chk("address", 8'h00, addr_q);
    chk("data", 32'h0000_0000, data_q);
    chk("stall", 0, stall);
    op(8'h01, 3);
    chk("erased", 32'hFFFF_FFFF, data_q);
    op(8'h06, EA + 2);
  endtask : t_reset
  task automatic t_update;
    core_port_model_inst.put(4, 8'h9F);
    for (int i = 0; i < 4; i++) core_port_model_inst.put(i, 8'h44 - 8'h11 * i);
    op(8'h02, PG + 2);
    op(8'h01, 3);
    chk("read", 32'h1122_3344, data_q);
    core_port_model_inst.put(1, 8'hF3);
    op(8'h05, EP + 2);
    op(8'h04, 3);
    chk("verify bad", 8'h01, cmd_q);
    op(8'h02, PG + 2);
    op(8'h04, 3);
    chk("verify ok", 8'h00, cmd_q);
    op(8'h01, 3);
    chk("update", 32'h1122_F344, data_q);
  endtask : t_update
  task automatic t_refuse;
    logic [7:0] codes [3] = '{8'h03, 8'h07, 8'hFF};
    foreach (codes[i]) begin
      op(codes[i], 0);
      chk("refused code", codes[i], cmd_q);
    end
    core_port_model_inst.put(4, 8'hA0);
    op(8'h05, 0);
    chk("address", 8'hA0, addr_q);
    core_port_model_inst.put(4, 8'h9F);
    op(8'h01, 3);
    chk("kept", 32'h1122_F344, data_q);
  endtask : t_refuse
  task automatic t_erase_all;
    op(8'h06, EA + 2);
    op(8'h01, 3);
    chk("all erased", 32'hFFFF_FFFF, data_q);
  endtask : t_erase_all
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_update();
    t_refuse();
    t_erase_all();
    stop_test();
  end
endmodule : tb
